// ===== safety_ctl_pkg.sv
// Purpose: Shared constants and types for the safety output controller.
// Assumes: 200 MHz system clock, AXI4-Lite register access.
// Notes:   Register offsets are byte addresses of 32-bit words.
`default_nettype none
package safety_ctl_pkg;
   // Clock and time base.
   localparam int CLK_KHZ        = 200000;
   localparam int ROT_MS         = 30;
   localparam int ROT_CYCLES_DEF = ROT_MS * CLK_KHZ;
   localparam int MS_CYCLES_DEF  = CLK_KHZ;
   localparam int MS_PER_S       = 1000;
   localparam logic [9:0] RESTART_MS = 10'h1F4;
   // Scan count limits and default.
   localparam logic [4:0] SCAN_MIN = 5'h02;
   localparam logic [4:0] SCAN_MAX = 5'h10;
   // Mute window in seconds, and recovery delay default in ms.
   localparam logic [4:0] WIN_MIN = 5'h01;
   localparam logic [4:0] WIN_MAX = 5'h10;
   localparam logic [4:0] WIN_DEF = 5'h04;
   localparam logic [15:0] RECOVERY_DEF = 16'h0000;
   // Register map.
   localparam logic [3:0] REG_CONFIG   = 4'h0;
   localparam logic [3:0] REG_RECOVERY = 4'h4;
   localparam logic [3:0] REG_STATUS   = 4'h8;
   // CONFIG fields.
   localparam int CFG_SCAN_LSB = 0;
   localparam int CFG_MANUAL   = 8;
   localparam int CFG_WIN_LSB  = 16;
   // STATUS fields and AXI response codes.
   localparam int ST_ON     = 0;
   localparam int ST_MUTED  = 1;
   localparam int ST_WAIT   = 2;
   localparam int ST_RECOV  = 3;
   localparam int ST_HITS   = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [4:0]  scan_count;
      logic        manual;
      logic [4:0]  win_s;
      logic [15:0] recovery_ms;
   } cfg_t;

   typedef enum logic [2:0] {
      S_START, S_ON, S_OFF, S_RECOVER, S_WAIT_RESET
   } safe_state_t;

   typedef enum logic [1:0] {
      M_WAIT_CLR, M_IDLE, M_FIRST, M_MUTED
   } mute_state_t;
endpackage
`default_nettype wire

// ===== safety_output_ctl.sv
// Purpose: Safety switching output, start/restart and mute control.
// Assumes: Detector logic shares aclk; button and mute pins are async.
// Notes:   Both output bits switch together from one state register.
// Function
// - One rotation lasts 30 ms; rotations are the response time unit.
// - Outputs switch off within configured response time after intrusion.
// - Shortest response is two rotations, 60 ms.
// - Scan count setting 2 to 16 rotations, default two.
// - Automatic mode: outputs on after self-test passes and zone clear.
// - Automatic mode: outputs return on unaided once zone clears.
// - Outputs held off for configurable recovery delay after zone clears.
// - Manual mode: outputs stay off after power-up until valid reset.
// - Restart accepted only after button held at least 500 ms.
// - Active mute suspends safeguarding; intrusion does not switch off.
// - Mute starts only if both inputs activate within 1-16 s window.
// - Both mute inputs activating together is refused as common fault.
// - Second input late beyond window: no mute.
// - Mute inputs active at power-up never produce a mute; a single one held here still opens the window.
// - Mute start and end follow only the mute input states.
// - Configuration selects automatic or manual restart.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module safety_output_ctl
   import safety_ctl_pkg::*;
#(
   parameter int ROT_CYCLES = ROT_CYCLES_DEF,
   parameter int MS_CYCLES  = MS_CYCLES_DEF
)(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write channels.
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read channels.
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Detector side.
   input  wire logic        zone_intrusion,
   input  wire logic        self_test_ok,
   // Pins.
   input  wire logic        restart_button,
   input  wire logic        mute_in1,
   input  wire logic        mute_in2,
   output logic [1:0]       safety_switch_output
);
   cfg_t        cfg;
   safe_state_t state;
   mute_state_t mstate;
   logic [2:0]  sy_btn, sy_m1, sy_m2;
   logic [22:0] rot_cnt;
   logic [17:0] ms_cnt;
   logic        seen_intr, zone_clear;
   logic [4:0]  hits;
   logic [15:0] rec_cnt;
   logic [9:0]  btn_ms;
   logic [13:0] win_ms;

   // Two-flop synchronisers; stage 0 feeds only stage 1.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sy_btn <= 3'h0;
         sy_m1  <= 3'h0;
         sy_m2  <= 3'h0;
      end else begin
         sy_btn <= {sy_btn[1:0], restart_button};
         sy_m1  <= {sy_m1[1:0], mute_in1};
         sy_m2  <= {sy_m2[1:0], mute_in2};
      end
   end
   wire btn    = sy_btn[1];
   wire m1     = sy_m1[1];
   wire m2     = sy_m2[1];
   wire m1_old = sy_m1[2];
   wire m2_old = sy_m2[2];

   // Time base: millisecond tick and rotation end tick.
   wire ms_tick = (ms_cnt == 18'(MS_CYCLES - 1));
   wire rot_end = (rot_cnt == 23'(ROT_CYCLES - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_cnt  <= 18'h0;
         rot_cnt <= 23'h0;
      end else begin
         ms_cnt  <= ms_tick ? 18'h0 : ms_cnt + 18'h1;
         rot_cnt <= rot_end ? 23'h0 : rot_cnt + 23'h1;
      end
   end

   // Per-rotation intrusion capture. A short intrusion inside a rotation
   // still counts, so a passing object cannot slip between samples.
   wire rot_hit  = seen_intr | zone_intrusion;
   wire [4:0] next_hits = (hits == SCAN_MAX) ? hits : hits + 5'h1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen_intr  <= 1'b0;
         hits       <= 5'h0;
         zone_clear <= 1'b0;
      end else if (rot_end) begin
         seen_intr  <= 1'b0;
         hits       <= rot_hit ? next_hits : 5'h0;
         zone_clear <= !rot_hit;
      end else if (zone_intrusion) begin
         seen_intr  <= 1'b1;
      end
   end
   // Trip once the configured number of consecutive rotations saw intrusion.
   wire trip = (hits >= cfg.scan_count);

   // Restart button hold timer; a press only counts once 500 ms are reached.
   wire restart_ok = btn && (btn_ms == RESTART_MS);
   always_ff @(posedge aclk) begin
      if (!aresetn || !btn)
         btn_ms <= 10'h0;
      else if (ms_tick && btn_ms != RESTART_MS)
         btn_ms <= btn_ms + 10'h1;
   end

   // Mute sequencer. It powers up in M_WAIT_CLR, which the reset synchronisers satisfy at once, so
   // inputs held active through power-up are seen rising: both are refused, a single one starts M_FIRST.
   wire both_rise = m1 && m2 && !m1_old && !m2_old;
   wire win_over  = (win_ms >= 14'(cfg.win_s) * 14'(MS_PER_S));
   wire muted     = (mstate == M_MUTED);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mstate <= M_WAIT_CLR;
         win_ms <= 14'h0;
      end else begin
         win_ms <= 14'h0;
         case (mstate)
            M_WAIT_CLR: begin
               if (!m1 && !m2)
                  mstate <= M_IDLE;
            end
            M_IDLE: begin
               if (both_rise)
                  mstate <= M_WAIT_CLR;
               else if (m1 != m2)
                  mstate <= M_FIRST;
               else if (m1 && m2)
                  mstate <= M_WAIT_CLR;
            end
            M_FIRST: begin
               if (!m1 && !m2)
                  mstate <= M_IDLE;
               else if (win_over)
                  mstate <= M_WAIT_CLR;
               else if (m1 && m2)
                  mstate <= M_MUTED;
               else if (ms_tick)
                  win_ms <= win_ms + 14'h1;
               else
                  win_ms <= win_ms;
            end
            M_MUTED: begin
               if (!m1 || !m2)
                  mstate <= M_WAIT_CLR;
            end
            default: mstate <= M_WAIT_CLR;
         endcase
      end
   end

   // Output state machine.
   wire rec_done = (rec_cnt >= cfg.recovery_ms);
   wire [15:0] next_rec = ms_tick ? rec_cnt + 16'h1 : rec_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state   <= S_START;
         rec_cnt <= 16'h0;
      end else begin
         rec_cnt <= 16'h0;
         case (state)
            S_START: begin
               if (self_test_ok && zone_clear)
                  state <= cfg.manual ? S_WAIT_RESET : S_ON;
            end
            S_ON: begin
               if (trip && !muted)
                  state <= S_OFF;
            end
            S_OFF: begin
               if (zone_clear)
                  state <= S_RECOVER;
            end
            S_RECOVER: begin
               if (!zone_clear)
                  state <= S_OFF;
               else if (rec_done)
                  state <= cfg.manual ? S_WAIT_RESET : S_ON;
               else
                  rec_cnt <= next_rec;
            end
            S_WAIT_RESET: begin
               if (!zone_clear)
                  state <= S_OFF;
               else if (restart_ok)
                  state <= S_ON;
            end
            default: state <= S_START;
         endcase
      end
   end

   // Both channels are driven from one registered decision.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         safety_switch_output <= 2'h0;
      else if (state == S_ON && !(trip && !muted))
         safety_switch_output <= 2'h3;
      else
         safety_switch_output <= 2'h0;
   end

   // AXI4-Lite write path: address and data are taken together once both
   // are offered, and nothing new is taken while a response is pending.
   wire wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                  !s_axi_awready;
   wire wr_cfg  = wr_go && (s_axi_awaddr == REG_CONFIG);
   wire wr_rec  = wr_go && (s_axi_awaddr == REG_RECOVERY);
   wire wr_ok   = wr_go && (s_axi_awaddr == REG_CONFIG ||
                  s_axi_awaddr == REG_RECOVERY || s_axi_awaddr == REG_STATUS);
   wire [4:0] wd_scan = s_axi_wdata[CFG_SCAN_LSB +: 5];
   wire [4:0] wd_win  = s_axi_wdata[CFG_WIN_LSB +: 5];
   // Out-of-range settings are clamped so the safety timing stays legal.
   wire [4:0] clamp_scan = (wd_scan < SCAN_MIN) ? SCAN_MIN :
                           (wd_scan > SCAN_MAX) ? SCAN_MAX : wd_scan;
   wire [4:0] clamp_win  = (wd_win < WIN_MIN) ? WIN_MIN :
                           (wd_win > WIN_MAX) ? WIN_MAX : wd_win;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg           <= '{SCAN_MIN, 1'b0, WIN_DEF, RECOVERY_DEF};
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_cfg && s_axi_wstrb[0])
            cfg.scan_count <= clamp_scan;
         if (wr_cfg && s_axi_wstrb[1])
            cfg.manual <= s_axi_wdata[CFG_MANUAL];
         if (wr_cfg && s_axi_wstrb[2])
            cfg.win_s <= clamp_win;
         if (wr_rec && s_axi_wstrb[0])
            cfg.recovery_ms[7:0] <= s_axi_wdata[7:0];
         if (wr_rec && s_axi_wstrb[1])
            cfg.recovery_ms[15:8] <= s_axi_wdata[15:8];
      end
   end

   // AXI4-Lite read path with address decode.
   wire rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
   wire [31:0] cfg_word = {11'h0, cfg.win_s, 7'h0, cfg.manual,
                           3'h0, cfg.scan_count};
   wire [31:0] stat_word = {19'h0, hits, 4'h0, state == S_RECOVER,
                           state == S_WAIT_RESET, muted,
                           safety_switch_output[0]};
   wire rd_hit = (s_axi_araddr == REG_CONFIG) ||
                 (s_axi_araddr == REG_RECOVERY) ||
                 (s_axi_araddr == REG_STATUS);
   wire [31:0] rd_word = (s_axi_araddr == REG_CONFIG)   ? cfg_word :
                         (s_axi_araddr == REG_RECOVERY) ?
                            {16'h0, cfg.recovery_ms} :
                         (s_axi_araddr == REG_STATUS)   ? stat_word : 32'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks on the safety behaviour.
   a_outputs_paired: assert property (
      @(posedge aclk) disable iff (!aresetn)
      safety_switch_output[0] == safety_switch_output[1])
      else $error("safety output channels disagree");
   a_trip_switches_off: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state == S_ON && trip && !muted |=> safety_switch_output == 2'h0
      ##1 state == S_OFF)
      else $error("trip did not switch outputs off");
   a_mute_keeps_on: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state == S_ON && muted && $past(muted) |=> state == S_ON)
      else $error("outputs left run state while muted");
   a_no_simul_mute: assert property (
      @(posedge aclk) disable iff (!aresetn)
      mstate == M_IDLE && both_rise |=> !muted [*3])
      else $error("simultaneous mute inputs were accepted");
   // Both inputs dropping in the overrun cycle legally returns to idle.
   a_late_no_mute: assert property (
      @(posedge aclk) disable iff (!aresetn)
      mstate == M_FIRST && win_over && (m1 || m2)
      |=> mstate == M_WAIT_CLR)
      else $error("mute window overrun not refused");
   a_mute_follows: assert property (
      @(posedge aclk) disable iff (!aresetn)
      muted && (!m1 || !m2) |=> !muted)
      else $error("mute outlived its inputs");
   a_recovery_off: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state == S_RECOVER |=> safety_switch_output == 2'h0)
      else $error("outputs on during recovery");
   a_manual_needs: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state == S_WAIT_RESET && !restart_ok |=> state != S_ON)
      else $error("manual restart without valid reset");
   a_restart_held: assert property (
      @(posedge aclk) disable iff (!aresetn)
      restart_ok |-> $past(btn, 2) && btn_ms == RESTART_MS)
      else $error("restart accepted too early");
   a_scan_range: assert property (
      @(posedge aclk) disable iff (!aresetn)
      cfg.scan_count >= SCAN_MIN && cfg.scan_count <= SCAN_MAX)
      else $error("scan count out of range");
   a_start_gated: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state == S_START && !(self_test_ok && zone_clear)
      |=> state == S_START)
      else $error("started without self-test and clear zone");
   c_trip: cover property (@(posedge aclk) disable iff (!aresetn)
      state == S_ON ##1 state == S_OFF);
   c_mute: cover property (@(posedge aclk) disable iff (!aresetn)
      mstate == M_FIRST ##1 muted);
   c_manual: cover property (@(posedge aclk) disable iff (!aresetn)
      state == S_WAIT_RESET ##1 state == S_ON);
   c_auto_recover: cover property (@(posedge aclk) disable iff (!aresetn)
      state == S_RECOVER ##1 state == S_ON);
endmodule
`default_nettype wire

// ===== safety_far_side.sv
// Purpose: Far-side model: restart push-button and two mute sensors.
// Assumes: The bench calls the tasks right after a rising edge.
// Notes:   Short presses and common faults happen only on command.
`timescale 1ns/1ps
`default_nettype none
module safety_far_side (
   // Clock.
   input  wire logic aclk,
   // Pins toward the controller.
   output var logic  restart_button,
   output var logic  mute_in1,
   output var logic  mute_in2
);
   // Unpowered sensors and a released button read inactive.
   initial begin
      restart_button = 1'b0;
      mute_in1       = 1'b0;
      mute_in2       = 1'b0;
   end

   // Holds the button steadily; a short hold is a deliberate misuse.
   task automatic press(input int cycles);
      @(posedge aclk);
      restart_button <= 1'b1;
      repeat (cycles) @(posedge aclk);
      restart_button <= 1'b0;
   endtask

   // Each sensor has its own wire, so they only move together on command.
   task automatic sense(input logic a, input logic b);
      @(posedge aclk);
      mute_in1 <= a;
      mute_in2 <= b;
   endtask
endmodule
`default_nettype wire

// ===== safety_output_start_mute_control_bench.sv
// Purpose: Self-checking bench for the safety output controller.
// Assumes: Rotation and millisecond counts are shortened for run time.
// Notes:   Bus results are noted in a queue and checked by a monitor.
`timescale 1ns/1ps
`default_nettype none
module safety_output_start_mute_control_bench;
   import safety_ctl_pkg::*;
   localparam int ROT = 40;
   localparam int MSC = 4;
   typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;}
      note_t;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, zone_intrusion, self_test_ok;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, restart_button, mute_in1, mute_in2;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp, safety_switch_output;
   note_t       notes[$];
   int          error_cnt, samples_checked, cycles, n, sc;
   logic [31:0] seed;

   safety_output_ctl #(.ROT_CYCLES(ROT), .MS_CYCLES(MSC)) uut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .zone_intrusion, .self_test_ok,
      .restart_button, .mute_in1, .mute_in2, .safety_switch_output);
   safety_far_side far (.aclk, .restart_button, .mute_in1, .mute_in2);

   // Free-running 200 MHz clock.
   initial aclk = 1'b0;
   always #2.5 aclk = ~aclk;

   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bus(input logic [31:0] d, input logic [1:0] r);
      note_t nt;
      nt = notes.pop_front();
      samples_checked++;
      if (((d & nt.mask) !== (nt.data & nt.mask)) || (r !== nt.resp)) begin
         error_cnt++;
         $display("[FAIL] %0t bus got %h/%h exp %h/%h", $time, d, r,
                  nt.data, nt.resp);
      end
   endtask

   // Monitor: every completed response consumes the oldest note.
   always @(posedge aclk) begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready) cmp_bus(32'h0, s_axi_bresp);
      if (s_axi_rvalid === 1'b1 && s_axi_rready) cmp_bus(s_axi_rdata,
                                                         s_axi_rresp);
   end

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      notes.push_back('{32'h0, 32'h0, er});
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      // The wait ends once s_axi_bvalid is seen; the bench's hang guard ends it otherwise.
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] e,
                         input logic [31:0] m, input logic [1:0] er);
      notes.push_back('{e, m, er});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Counts cycles until the outputs show e, giving up after mx.
   task automatic wait_out(input logic [1:0] e, input int mx, output int c);
      c = 0;
      while (safety_switch_output !== e && c < mx) begin
         @(posedge aclk);
         c++;
      end
   endtask

   task automatic zone(input logic v);
      @(posedge aclk);
      zone_intrusion <= v;
   endtask

   task automatic trip;
      int c;
      zone(1'b1);
      wait_out(2'h0, 17 * ROT, c);
      zone(1'b0);
   endtask

   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask

   task automatic test_done;
      if (notes.size() != 0) error_cnt++;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Hang guard, well above the expected run of about 15000 cycles.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      error_cnt = 0;
      samples_checked = 0;
      seed = 32'h22df;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, zone_intrusion, self_test_ok} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wait_out(2'h3, 4 * ROT, n);
      cmp_val(n, 4 * ROT);
      self_test_ok <= 1'b1;
      wait_out(2'h3, 3 * ROT, n);
      cmp_val(safety_switch_output, 2'h3);
      end_test("power-up");
      axi_rd(REG_CONFIG, {11'h0, WIN_DEF, 7'h0, 1'b0, 3'h0, SCAN_MIN},
             32'h001F_011F, RESP_OKAY);
      axi_rd(REG_RECOVERY, 32'h0, 32'h0000_FFFF, RESP_OKAY);
      axi_rd(4'hC, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
      axi_wr(4'hC, 32'h0000_FFFF, RESP_SLVERR);
      axi_wr(REG_STATUS, 32'h0, RESP_OKAY);
      axi_wr(REG_CONFIG, 32'h0004_0011, RESP_OKAY);
      axi_rd(REG_CONFIG, {11'h0, WIN_DEF, 11'h0, SCAN_MAX},
             32'h001F_011F, RESP_OKAY);
      end_test("registers");
      // Trip at the shortest, longest and a random scan count.
      for (int i = 0; i < 3; i++) begin
         sc = (i == 0) ? 2 : (i == 1) ? 16 : 2 + int'({$random(seed)} % 15);
         axi_wr(REG_CONFIG, {11'h0, WIN_DEF, 11'h0, sc[4:0]}, RESP_OKAY);
         zone(1'b1);
         wait_out(2'h0, 17 * ROT, n);
         cmp_val(n >= (sc - 1) * ROT && n <= sc * ROT + 3, 1);
         zone(1'b0);
         wait_out(2'h3, 3 * ROT, n);
         cmp_val(safety_switch_output, 2'h3);
      end
      end_test("response");
      axi_wr(REG_CONFIG, {11'h0, WIN_DEF, 11'h0, SCAN_MIN}, RESP_OKAY);
      axi_wr(REG_RECOVERY, 32'h0000_0014, RESP_OKAY);
      trip();
      wait_out(2'h3, 6 * ROT, n);
      cmp_val(safety_switch_output, 2'h3);
      cmp_val(n >= ROT + 20 * MSC && n <= 2 * ROT + 21 * MSC + 4, 1);
      end_test("recovery");
      axi_wr(REG_RECOVERY, 32'h0, RESP_OKAY);
      axi_wr(REG_CONFIG, {11'h0, WIN_DEF, 7'h0, 1'b1, 3'h0, SCAN_MIN},
             RESP_OKAY);
      trip();
      wait_out(2'h3, 4 * ROT, n);
      cmp_val(n, 4 * ROT);
      axi_rd(REG_STATUS, 32'h0000_0004, 32'h0000_000F, RESP_OKAY);
      far.press(490 * MSC);
      wait_out(2'h3, 4 * ROT, n);
      cmp_val(n, 4 * ROT);
      far.press(500 * MSC + 40);
      cmp_val(safety_switch_output, 2'h3);
      end_test("manual");
      // Second reset with both sensors already active.
      far.sense(1'b1, 1'b1);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wait_out(2'h3, 4 * ROT, n);
      cmp_val(safety_switch_output, 2'h3);
      zone(1'b1);
      wait_out(2'h0, 3 * ROT, n);
      cmp_val(safety_switch_output, 2'h0);
      zone(1'b0);
      far.sense(1'b0, 1'b0);
      wait_out(2'h3, 4 * ROT, n);
      cmp_val(safety_switch_output, 2'h3);
      far.sense(1'b1, 1'b1);
      repeat (8) @(posedge aclk);
      axi_rd(REG_STATUS, 32'h0000_0001, 32'h0000_0003, RESP_OKAY);
      far.sense(1'b0, 1'b0);
      end_test("mute refusal");
      // One-second window: in time either order, then late.
      axi_wr(REG_CONFIG, {11'h0, WIN_MIN, 11'h0, SCAN_MIN}, RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
         far.sense(i != 1, i == 1);
         repeat ((i == 2 ? 1100 : 500) * MSC) @(posedge aclk);
         far.sense(1'b1, 1'b1);
         repeat (8) @(posedge aclk);
         axi_rd(REG_STATUS, {30'h0, i != 2, 1'b1}, 32'h0000_0003,
                RESP_OKAY);
         if (i != 2) begin
            zone(1'b1);
            repeat (4 * ROT) @(posedge aclk);
            cmp_val(safety_switch_output, 2'h3);
            far.sense(1'b0, 1'b1);
            wait_out(2'h0, 10, n);
            cmp_val(safety_switch_output, 2'h0);
            zone(1'b0);
         end
         far.sense(1'b0, 1'b0);
         wait_out(2'h3, 4 * ROT, n);
         cmp_val(safety_switch_output, 2'h3);
      end
      end_test("mute window");
      test_done();
   end
endmodule
`default_nettype wire
